/* File: tb/dog_reset_cause_flag_top_bench.sv */
// Self-checking bench for the watchdog block and its reset-cause register.
module dog_reset_cause_flag_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dog_reset_cause_flag_pkg::*;

  typedef struct {logic rd; logic [31:0] d; logic err;} dog_reset_cause_flag_note_t;
  // Short counts keep the longest time-out near eight thousand clocks.
  localparam int OSC = 4;
  localparam int BASE = 4;
  localparam int LIMIT = 40000;
  localparam logic [9:0] CT = DOG_RESET_CAUSE_FLAG_CTRL_ADDR;
  localparam logic [9:0] CA = DOG_RESET_CAUSE_FLAG_CAUSE_ADDR;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic safety_level_fuse = 1'b0;
  logic global_irq_enable = 1'b0;
  logic irq_taken = 1'b0;
  logic restart_cmd = 1'b0;
  logic pin_reset_event = 1'b0;
  logic brownout_event = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq_req;
  logic dog_reset_pulse;
  dog_reset_cause_flag_note_t notes[$];
  dog_reset_cause_flag_note_t note;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  int pulse_cnt = 0;
  int n;
  logic [3:0] s;

  dog_reset_cause_flag_top #(.OSC_DIV(OSC), .TIMEOUT_BASE(BASE)) dog_reset_cause_flag_top_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .safety_level_fuse(safety_level_fuse),
    .global_irq_enable(global_irq_enable), .irq_taken(irq_taken), .restart_cmd(restart_cmd),
    .pin_reset_event(pin_reset_event), .brownout_event(brownout_event), .irq_req(irq_req),
    .dog_reset_pulse(dog_reset_pulse));

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running system clock.
  initial begin
    forever #4 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One APB transfer; hold keeps the bus so the next setup follows at once.
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [7:0] d,
                      input logic [7:0] exp, input logic err, input logic hold);
    notes.push_back('{!wr, {24'h0, exp}, err});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    if (!hold) begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 8'h00, 1'b0, 1'b0);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00, e, 1'b0, 1'b0);
  endtask

  // Opens the change window and writes the new value straight after it.
  task automatic set_ctrl(input logic [7:0] v);
    xfer(1'b1, CT, 8'h18, 8'h00, 1'b0, 1'b1);
    xfer(1'b1, CT, v, 8'h00, 1'b0, 1'b0);
  endtask

  task automatic fire(input logic [3:0] v);
    {restart_cmd, irq_taken, brownout_event, pin_reset_event} <= v;
    @(posedge clk);
    {restart_cmd, irq_taken, brownout_event, pin_reset_event} <= 4'h0;
    @(posedge clk);
  endtask

  // Counts clocks until the request or the reset pulse is seen high at an edge.
  task automatic wait_sig(input logic dog, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (cnt < 20000 && (dog ? dog_reset_pulse !== 1'b1 : irq_req !== 1'b1));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: every answered transfer is compared with the oldest note.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (dog_reset_pulse === 1'b1)
      pulse_cnt++;
    if (pready === 1'b1 && notes.size() == 0)
      check("unexpected_pready", 32'h1, 32'h0);
    else if (pready === 1'b1) begin
      note = notes.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, note.err});
      if (note.rd)
        check("prdata", prdata, note.d);
    end
    if (cycles == LIMIT) begin
      check("cycle_limit", 32'h1, 32'h0);
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    void'($urandom(32'habdf4114));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(CA, 8'h01);
    rd(CT, 8'h00);
    xfer(1'b0, 10'h000, 8'h00, 8'h00, 1'b1, 1'b0);
    wr(CA, 8'hff);
    rd(CA, 8'h01);
    pstrb <= 4'he;
    wr(CA, 8'h00);
    pstrb <= 4'hf;
    rd(CA, 8'h01);
    wr(CA, 8'h00);
    rd(CA, 8'h00);
    fire(4'h1);
    rd(CA, 8'h02);
    fire(4'h2);
    rd(CA, 8'h06);
    wr(CA, 8'h00);
    rd(CA, 8'h00);
    $display("test cause_flags done");
    // Longest select first, so the protection checks never hit a time-out.
    set_ctrl(8'h2f);
    wr(CT, 8'h08);
    rd(CT, 8'h2f);
    wr(CT, 8'h20);
    rd(CT, 8'h2f);
    wr(CT, 8'h3f);
    repeat (2) @(posedge clk);
    wr(CT, 8'h00);
    rd(CT, 8'h2f);
    set_ctrl(8'h00);
    rd(CT, 8'h00);
    for (int i = 0; i < 4; i++) begin
      s = 4'($urandom());
      set_ctrl({2'b00, s[3], 2'b00, s[2:0]});
      rd(CT, {2'b00, s[3], 2'b00, s[2:0]});
    end
    $display("test protection done");
    global_irq_enable <= 1'b1;
    set_ctrl(8'h40);
    wait_sig(1'b0, n);
    check("first_span", {31'h0, n >= 4 && n <= 20}, 32'h1);
    fire(4'h4);
    @(posedge clk);
    check("irq_after_vector", {31'h0, irq_req}, 32'h0);
    wait_sig(1'b0, n);
    check("repeat_span", {31'h0, n >= 11 && n <= 15}, 32'h1);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge clk);
    check("irq_masked", {31'h0, irq_req}, 32'h0);
    set_ctrl(8'h00);
    repeat (40) @(posedge clk);
    rd(CT, 8'h80);
    check("no_reset_when_stopped", pulse_cnt, 0);
    wr(CT, 8'h80);
    rd(CT, 8'h00);
    global_irq_enable <= 1'b1;
    set_ctrl(8'h62);
    wait_sig(1'b0, n);
    check("reserved_span", {31'h0, n >= 8170 && n <= 8200}, 32'h1);
    set_ctrl(8'h00);
    wr(CT, 8'h80);
    $display("test interrupt_mode done");
    set_ctrl(8'h48);
    wait_sig(1'b0, n);
    check("both_span", {31'h0, n >= 4 && n <= 20}, 32'h1);
    rd(CT, 8'h88);
    wait_sig(1'b1, n);
    check("reset_span", {31'h0, n >= 6 && n <= 16}, 32'h1);
    @(posedge clk);
    check("pulse_width", {31'h0, dog_reset_pulse}, 32'h0);
    set_ctrl(8'h2f);
    rd(CT, 8'h2f);
    rd(CA, 8'h08);
    set_ctrl(8'h20);
    rd(CT, 8'h28);
    wr(CA, 8'h00);
    set_ctrl(8'h00);
    rd(CT, 8'h00);
    check("pulse_count", pulse_cnt, 1);
    set_ctrl(8'h08);
    for (int i = 0; i < 12; i++) begin
      fire(4'h8);
      repeat (3) @(posedge clk);
    end
    check("restart_holds", pulse_cnt, 1);
    set_ctrl(8'h00);
    $display("test reset_mode done");
    safety_level_fuse <= 1'b1;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    set_ctrl(8'h27);
    rd(CT, 8'h2f);
    rd(CA, 8'h01);
    set_ctrl(8'h20);
    rd(CT, 8'h28);
    $display("test safety_level done");
    complete_run();
  end

endmodule // dog_reset_cause_flag_top_bench

/* File: verilog/dog_reset_cause_flag_pkg.sv */
// Package with the register map, field positions and timing constants of the watchdog block.
package dog_reset_cause_flag_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices and byte addresses.
  localparam logic [7:0] DOG_RESET_CAUSE_FLAG_CTRL_INDEX = 8'h21;
  localparam logic [7:0] DOG_RESET_CAUSE_FLAG_CAUSE_INDEX = 8'h22;
  localparam logic [9:0] DOG_RESET_CAUSE_FLAG_CTRL_ADDR = {DOG_RESET_CAUSE_FLAG_CTRL_INDEX, 2'h0};
  localparam logic [9:0] DOG_RESET_CAUSE_FLAG_CAUSE_ADDR = {DOG_RESET_CAUSE_FLAG_CAUSE_INDEX, 2'h0};

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions of watchdog_control.
  localparam int DOG_RESET_CAUSE_FLAG_IRQ_FLAG_BIT = 7;
  localparam int DOG_RESET_CAUSE_FLAG_IRQ_EN_BIT = 6;
  localparam int DOG_RESET_CAUSE_FLAG_SEL3_BIT = 5;
  localparam int DOG_RESET_CAUSE_FLAG_CE_BIT = 4;
  localparam int DOG_RESET_CAUSE_FLAG_EN_BIT = 3;
  localparam int DOG_RESET_CAUSE_FLAG_SEL2_BIT = 2;
  localparam int DOG_RESET_CAUSE_FLAG_SEL1_BIT = 1;
  localparam int DOG_RESET_CAUSE_FLAG_SEL0_BIT = 0;

  // Field positions of reset_cause_status.
  localparam int DOG_RESET_CAUSE_FLAG_DOG_FLAG_BIT = 3;
  localparam int DOG_RESET_CAUSE_FLAG_BOR_FLAG_BIT = 2;
  localparam int DOG_RESET_CAUSE_FLAG_PIN_FLAG_BIT = 1;
  localparam int DOG_RESET_CAUSE_FLAG_POR_FLAG_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and the largest valid select code.
  localparam logic [3:0] DOG_RESET_CAUSE_FLAG_SEL_RESET = 4'h0;
  localparam logic [3:0] DOG_RESET_CAUSE_FLAG_SEL_MAX = 4'h9;
  localparam logic [7:0] DOG_RESET_CAUSE_FLAG_CAUSE_POR_VALUE = 8'h01;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing: the watchdog oscillator tick is an enable derived from the system clock.
  localparam int DOG_RESET_CAUSE_FLAG_SYS_HZ = 125000000;
  localparam int DOG_RESET_CAUSE_FLAG_OSC_HZ = 128000;
  localparam int DOG_RESET_CAUSE_FLAG_OSC_DIV = DOG_RESET_CAUSE_FLAG_SYS_HZ / DOG_RESET_CAUSE_FLAG_OSC_HZ;
  localparam int DOG_RESET_CAUSE_FLAG_TIMEOUT_BASE = 2048;
  localparam logic [2:0] DOG_RESET_CAUSE_FLAG_CE_CYCLES = 3'h4;

endpackage : dog_reset_cause_flag_pkg

/* File: verilog/dog_reset_cause_flag_top.sv */
// Watchdog timer with reset-cause status register, reached over APB.
//
// What this block and its software do
// R1: Cause register upper four bits read zero.
// R2: Watchdog reset sets flag; power-on or zero-write clears.
// R3: Brown-out sets flag; power-on or zero-write clears.
// R4: Pin reset sets flag; power-on or zero-write clears.
// R5: Power-on sets flag; only zero-write clears.
// R6: Time-out in interrupt mode sets interrupt flag.
// R7: Vector taken or one-write clears interrupt flag.
// R8: Request needs global enable, flag, and local enable or an owed combined-mode time-out.
// R9: Enables pick stop, interrupt or reset.
// R10: Both enables: time-out clears interrupt enable.
// R11: Change-enable clears itself four cycles later.
// R12: Zero to enable ignored without change-enable.
// R13: Time-out select written only under change-enable.
// R14: Software disables via timed two-write sequence.
// R15: Higher safety level keeps watchdog enabled.
// R16: Watchdog-reset flag forces enable at lower level.
// R17: Select code maps 2048 doubling to 1048576.
// R18: Reserved select codes use a valid setting.
// R19: Init software clears watchdog flag and enable.
// R20: Software reads then clears the cause register.
// R21: Counter runs on a 128 kHz oscillator tick.
// R22: Counter restarts on restart, disable, device reset.
// R23: Watchdog reset pulse lasts one clock.
// R24: Higher safety level reads enable as one.
// R25: Counter restarts from zero after each time-out.
//
// The implementer's own choice: the APB register port.
module dog_reset_cause_flag_top #(
  parameter int OSC_DIV = dog_reset_cause_flag_pkg::DOG_RESET_CAUSE_FLAG_OSC_DIV,          // System clocks per oscillator tick.
  parameter int TIMEOUT_BASE = dog_reset_cause_flag_pkg::DOG_RESET_CAUSE_FLAG_TIMEOUT_BASE // Ticks for select code zero.
) (
  input wire logic clk,                 // System clock, 125 MHz.
  input wire logic rst_n,               // Power-on reset, synchronous, active low.
  input wire logic psel,                // APB select.
  input wire logic penable,             // APB access phase.
  input wire logic pwrite,              // APB direction, high for write.
  input wire logic [9:0] paddr,         // APB byte address.
  input wire logic [31:0] pwdata,       // APB write data.
  input wire logic [3:0] pstrb,         // APB byte strobes; lane 0 holds the register.
  output logic [31:0] prdata,           // APB read data.
  output logic pready,                  // APB ready.
  output logic pslverr,                 // APB error for unmapped addresses.
  input wire logic safety_level_fuse,   // High selects the higher safety level.
  input wire logic global_irq_enable,   // Global interrupt enable of cpu_status_word.
  input wire logic irq_taken,           // Pulse: watchdog interrupt vector taken.
  input wire logic restart_cmd,         // Pulse: watchdog-restart instruction executed.
  input wire logic pin_reset_event,     // Pulse: external pin reset happened.
  input wire logic brownout_event,      // Pulse: brown-out reset happened.
  output logic irq_req,                 // Watchdog time-out interrupt request.
  output logic dog_reset_pulse          // One-clock system reset from the watchdog.
);
  import dog_reset_cause_flag_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Reserved select codes fall back to the longest valid period.
  function automatic logic [3:0] eff_select(input logic [3:0] code);
    eff_select = (code > DOG_RESET_CAUSE_FLAG_SEL_MAX) ? DOG_RESET_CAUSE_FLAG_SEL_MAX : code; // R18
  endfunction

  // Time-out length in oscillator ticks minus one, for the terminal compare.
  function automatic logic [20:0] last_tick(input logic [3:0] code);
    logic [20:0] len;
    len = 21'(TIMEOUT_BASE) << eff_select(code); // R17
    last_tick = len - 21'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State.
  logic timeout_irq_flag;
  logic timeout_irq_enable;
  logic change_enable;
  logic dog_enable;
  logic [3:0] timeout_select;
  logic [2:0] ce_count;
  logic dog_reset_cause_flag;
  logic brownout_cause_flag;
  logic pin_reset_cause_flag;
  logic poweron_cause_flag;
  logic [9:0] div_count;
  logic osc_tick;
  logic [20:0] wd_count;
  logic irq_owed;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode. A write lands at the edge where pready is sampled high.
  logic hit_ctrl;
  logic hit_cause;
  logic wr_fire;
  logic ctl_write;
  logic st_write;
  logic ce_load;
  logic dev_rst;
  logic running;
  logic timeout;
  logic [7:0] ctrl_view;
  logic [7:0] cause_view;

  assign hit_ctrl = (paddr == DOG_RESET_CAUSE_FLAG_CTRL_ADDR);
  assign hit_cause = (paddr == DOG_RESET_CAUSE_FLAG_CAUSE_ADDR);
  assign wr_fire = psel && penable && pready && pwrite && pstrb[0];
  assign ctl_write = wr_fire && hit_ctrl;
  assign st_write = wr_fire && hit_cause;
  assign ce_load = ctl_write && pwdata[DOG_RESET_CAUSE_FLAG_CE_BIT];

  // Any device reset other than power-on: pin, brown-out or our own pulse.
  assign dev_rst = dog_reset_pulse || pin_reset_event || brownout_event;

  // Counter runs whenever either enable is set; both clear stops it.
  assign running = dog_enable || timeout_irq_enable; // R9
  assign timeout = running && osc_tick && (wd_count == last_tick(timeout_select));

  // Read views. The enable reads one at the higher safety level.
  assign ctrl_view = {timeout_irq_flag, timeout_irq_enable, timeout_select[3], change_enable,
                      dog_enable || safety_level_fuse, timeout_select[2:0]}; // R24
  assign cause_view = {4'h0, dog_reset_cause_flag, brownout_cause_flag, // R1
                       pin_reset_cause_flag, poweron_cause_flag};

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, so pready rises in the second access cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !(hit_ctrl || hit_cause);
      prdata <= hit_ctrl ? {24'h0, ctrl_view} : (hit_cause ? {24'h0, cause_view} : 32'h0);
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator tick: a divider stands in for the separate slow oscillator.
  // The tick is slightly fast since the division rounds down; that errs toward safety.
  always_ff @(posedge clk) begin
    if (!rst_n || div_count == 10'(OSC_DIV - 1)) begin
      div_count <= 10'h0;
    end else begin
      div_count <= div_count + 10'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_tick <= 1'b0;
    end else begin
      osc_tick <= (div_count == 10'(OSC_DIV - 1)); // R21
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog counter in oscillator ticks.
  always_ff @(posedge clk) begin
    if (!rst_n || dev_rst || restart_cmd || !running || timeout) begin
      wd_count <= 21'h0; // R22 R25
    end else if (osc_tick) begin
      wd_count <= wd_count + 21'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Change-enable window: set by a write of one, cleared four clocks later.
  always_ff @(posedge clk) begin
    if (!rst_n || dev_rst) begin
      change_enable <= 1'b0;
      ce_count <= 3'h0;
    end else if (ce_load) begin
      change_enable <= 1'b1;
      ce_count <= DOG_RESET_CAUSE_FLAG_CE_CYCLES;
    end else if (ce_count != 3'h0) begin
      ce_count <= ce_count - 3'h1;
      change_enable <= (ce_count != 3'h1); // R11
    end else begin
      change_enable <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog enable with its guards and forcing terms.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dog_enable <= 1'b0;
    end else if (safety_level_fuse) begin
      dog_enable <= 1'b1; // R15
    end else if (dog_reset_cause_flag) begin
      dog_enable <= 1'b1; // R16
    end else if (dev_rst) begin
      dog_enable <= 1'b0;
    end else if (ctl_write) begin
      if (pwdata[DOG_RESET_CAUSE_FLAG_EN_BIT]) begin
        dog_enable <= 1'b1;
      end else if (change_enable) begin
        dog_enable <= 1'b0; // R12
      end
    end
  end

  // Time-out select, changed only inside the window.
  always_ff @(posedge clk) begin
    if (!rst_n || dev_rst) begin
      timeout_select <= DOG_RESET_CAUSE_FLAG_SEL_RESET;
    end else if (ctl_write && change_enable) begin
      timeout_select <= {pwdata[DOG_RESET_CAUSE_FLAG_SEL3_BIT], pwdata[DOG_RESET_CAUSE_FLAG_SEL2_BIT], // R13
                         pwdata[DOG_RESET_CAUSE_FLAG_SEL1_BIT], pwdata[DOG_RESET_CAUSE_FLAG_SEL0_BIT]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt enable: hardware clears it at a time-out when the reset enable is set,
  // so a missed service turns the next time-out into a reset.
  always_ff @(posedge clk) begin
    if (!rst_n || dev_rst) begin
      timeout_irq_enable <= 1'b0;
    end else if (timeout && dog_enable && timeout_irq_enable) begin
      timeout_irq_enable <= 1'b0; // R10
    end else if (ctl_write) begin
      timeout_irq_enable <= pwdata[DOG_RESET_CAUSE_FLAG_IRQ_EN_BIT];
    end
  end

  // Interrupt flag: a time-out in the same cycle as a clear wins.
  always_ff @(posedge clk) begin
    if (!rst_n || dev_rst) begin
      timeout_irq_flag <= 1'b0;
    end else if (timeout && timeout_irq_enable) begin
      timeout_irq_flag <= 1'b1; // R6 R9
    end else if (irq_taken || (ctl_write && pwdata[DOG_RESET_CAUSE_FLAG_IRQ_FLAG_BIT])) begin
      timeout_irq_flag <= 1'b0; // R7
    end
  end

  // With both enables set, the time-out clears the interrupt enable in the same edge that
  // raises the flag. That time-out still owes its interrupt, so it stays owed until the
  // flag is cleared; without this the combined mode would never interrupt at all.
  always_ff @(posedge clk) begin
    if (!rst_n || dev_rst) begin
      irq_owed <= 1'b0;
    end else if (timeout && dog_enable && timeout_irq_enable) begin
      irq_owed <= 1'b1; // R9 R10
    end else if (!timeout_irq_flag) begin
      irq_owed <= 1'b0;
    end
  end

  // Registered request to the interrupt controller.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= global_irq_enable && (timeout_irq_enable || irq_owed) && timeout_irq_flag; // R8 R9
    end
  end

  // Reset pulse when only the reset enable is set.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dog_reset_pulse <= 1'b0;
    end else begin
      dog_reset_pulse <= timeout && dog_enable && !timeout_irq_enable; // R9 R23
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset-cause flags. Power-on clears all but its own; a set beats a zero-write.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dog_reset_cause_flag <= 1'b0;
    end else if (timeout && dog_enable && !timeout_irq_enable) begin
      dog_reset_cause_flag <= 1'b1; // R2
    end else if (st_write && !pwdata[DOG_RESET_CAUSE_FLAG_DOG_FLAG_BIT]) begin
      dog_reset_cause_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      brownout_cause_flag <= 1'b0;
    end else if (brownout_event) begin
      brownout_cause_flag <= 1'b1; // R3
    end else if (st_write && !pwdata[DOG_RESET_CAUSE_FLAG_BOR_FLAG_BIT]) begin
      brownout_cause_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_reset_cause_flag <= 1'b0;
    end else if (pin_reset_event) begin
      pin_reset_cause_flag <= 1'b1; // R4
    end else if (st_write && !pwdata[DOG_RESET_CAUSE_FLAG_PIN_FLAG_BIT]) begin
      pin_reset_cause_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      poweron_cause_flag <= DOG_RESET_CAUSE_FLAG_CAUSE_POR_VALUE[DOG_RESET_CAUSE_FLAG_POR_FLAG_BIT]; // R5
    end else if (st_write && !pwdata[DOG_RESET_CAUSE_FLAG_POR_FLAG_BIT]) begin
      poweron_cause_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_reset_timeout;
    timeout && dog_enable && !timeout_irq_enable;
  endsequence

  sequence s_ce_quiet;
    ce_load ##1 (!ce_load)[*4];
  endsequence

  sequence s_both_timeout;
    timeout && dog_enable && timeout_irq_enable;
  endsequence

  property p_upper_zero;
    pready && !pwrite && hit_cause |-> prdata[7:4] == 4'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("cause upper bits not zero"); // R1

  property p_dog_flag;
    s_reset_timeout |=> dog_reset_pulse && dog_reset_cause_flag ##1 !dog_reset_pulse;
  endproperty
  a_dog_flag: assert property (p_dog_flag) else $error("watchdog reset pulse or flag wrong"); // R2

  property p_poweron_kept;
    $fell(poweron_cause_flag) |-> $past(st_write) && !$past(pwdata[DOG_RESET_CAUSE_FLAG_POR_FLAG_BIT]);
  endproperty
  a_poweron_kept: assert property (p_poweron_kept) else $error("power-on flag lost"); // R5

  property p_irq_set;
    timeout && timeout_irq_enable |=> timeout_irq_flag;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt flag not set"); // R6

  property p_irq_req;
    irq_req |-> $past(global_irq_enable) && $past(timeout_irq_flag);
  endproperty
  a_irq_req: assert property (p_irq_req) else $error("request without cause"); // R8

  property p_irq_both;
    s_both_timeout ##1 (global_irq_enable && timeout_irq_flag) |=> irq_req;
  endproperty
  a_irq_both: assert property (p_irq_both) else $error("combined mode gave no interrupt"); // R9

  property p_ie_clear;
    timeout && dog_enable && timeout_irq_enable |=> !timeout_irq_enable && !dog_reset_pulse;
  endproperty
  a_ie_clear: assert property (p_ie_clear) else $error("interrupt enable kept"); // R10

  property p_ce_hold;
    ce_load |=> change_enable[*4];
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("change window too short"); // R11

  property p_ce_end;
    s_ce_quiet |=> !change_enable;
  endproperty
  a_ce_end: assert property (p_ce_end) else $error("change window too long"); // R11

  property p_dis_guard;
    $fell(dog_enable) |-> $past(change_enable) || $past(dev_rst);
  endproperty
  a_dis_guard: assert property (p_dis_guard) else $error("enable cleared unguarded"); // R12

  property p_sel_guard;
    $changed(timeout_select) |-> $past(change_enable && ctl_write) || $past(dev_rst);
  endproperty
  a_sel_guard: assert property (p_sel_guard) else $error("select changed unguarded"); // R13

  property p_level2;
    safety_level_fuse |=> dog_enable;
  endproperty
  a_level2: assert property (p_level2) else $error("enable dropped at level two"); // R15

  property p_restart;
    restart_cmd |=> wd_count == 21'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("counter not restarted"); // R22

endmodule // dog_reset_cause_flag_top
